/* scss_ext_party.sv */
`timescale 1ns/1ps
// ****************************************
// Far side: outside clock source and pin load
// ****************************************
module scss_ext_party (
    input wire logic aclk,
    input wire logic run,
    input wire logic gpio_lvl,
    input wire logic in_oe,
    input wire logic in_out,
    input wire logic out_oe,
    input wire logic out_out,
    output logic in_pin,
    output logic out_pin
);
    logic [1:0] div_r = 2'h0;
    logic clk_r = 1'b0;
    // Period of 8 aclk, well below the sampling limit
    always @(posedge aclk) begin
        div_r <= run ? div_r + 2'h1 : 2'h0;
        if (!run) begin
            clk_r <= 1'b0;
        end else if (div_r == 2'h3) begin
            clk_r <= ~clk_r;
        end
    end
    // Device drive wins; otherwise clock or static load level
    assign in_pin = in_oe ? in_out : (run ? clk_r : gpio_lvl);
    assign out_pin = out_oe ? out_out : gpio_lvl;
endmodule : scss_ext_party

/* scss_pkg.sv */
package scss_pkg;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [7:0] OFS_FREQ_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRIM = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h14;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h18;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int FSEL_LSB = 4;
    localparam int LOCK_BIT = 3;
    localparam int STABLE_BIT = 2;
    localparam int TRIM_W = 6;
    localparam int IRQ_LOCK_BIT = 0;
    localparam int IRQ_STABLE_BIT = 1;
    localparam int PIN_IN_OUT_BIT = 0;
    localparam int PIN_IN_OE_BIT = 1;
    localparam int PIN_OUT_OUT_BIT = 2;
    localparam int PIN_OUT_OE_BIT = 3;

    // ********************************************************
    // Reset values and codes
    // ********************************************************
    localparam logic [1:0] FSEL_RESET = 2'h2;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
    localparam logic [1:0] MODE_EXT_CLOCK_OUTPUT_PIN = 2'h3;
    localparam logic [1:0] MODE_EXT_IO = 2'h2;
    localparam logic [1:0] MODE_INT_CLOCK_OUTPUT_PIN = 2'h1;
    localparam logic [1:0] MODE_INT_IO = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************
    // Frequencies and timing
    // ********************************************************
    localparam int CLK_FREQ_KHZ = 20000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int REF_FREQ_KHZ = 500;
    localparam int HF_FREQ_KHZ = 16000;
    localparam int ACC_W = 24;
    localparam logic [ACC_W-1:0] INC_HF = ACC_W'((64'(HF_FREQ_KHZ) << ACC_W) / 64'(CLK_FREQ_KHZ));
    localparam logic [ACC_W-1:0] INC_MF = ACC_W'((64'(REF_FREQ_KHZ) << ACC_W) / 64'(CLK_FREQ_KHZ));
    localparam int LOCK_TIME_NS = 20000;
    localparam int STABLE_TIME_NS = 100000;
    localparam int TRIM_STEP_NS = 5000;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STABLE_CYCLES = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIM_STEP_CYCLES = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : scss_pkg

/* scss_top.sv */
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module scss_top
    import scss_pkg::*;
#(
    parameter int LOCK_CNT = LOCK_CYCLES,
    parameter int STABLE_CNT = STABLE_CYCLES,
    parameter int TRIM_STEP_CNT = TRIM_STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] source_mode_field,
    input wire logic high_range_enable,
    input wire logic clock_input_pin_in,
    output logic clock_input_pin_out,
    output logic clock_input_pin_oe,
    input wire logic clock_output_pin_in,
    output logic clock_output_pin_out,
    output logic clock_output_pin_oe,
    output logic sys_clk_tick,
    output logic irq
);

    // ********************************************************
    // Pin and configuration synchronisers
    // ********************************************************
    logic [1:0] mode_s1_r, mode_r;
    logic range_s1_r, range_r;
    logic cin_s1_r, cin_r, cin_d_r;
    logic cout_s1_r, cout_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_s1_r <= MODE_INT_IO;
            mode_r <= MODE_INT_IO;
            range_s1_r <= 1'b0;
            range_r <= 1'b0;
            cin_s1_r <= 1'b0;
            cin_r <= 1'b0;
            cin_d_r <= 1'b0;
            cout_s1_r <= 1'b0;
            cout_r <= 1'b0;
        end else begin
            mode_s1_r <= source_mode_field;
            mode_r <= mode_s1_r;
            range_s1_r <= high_range_enable;
            range_r <= range_s1_r;
            cin_s1_r <= clock_input_pin_in;
            cin_r <= cin_s1_r;
            cin_d_r <= cin_r;
            cout_s1_r <= clock_output_pin_in;
            cout_r <= cout_s1_r;
        end
    end

    // Mode decode
    wire mode_ext = (mode_r == MODE_EXT_CLOCK_OUTPUT_PIN) || (mode_r == MODE_EXT_IO);
    wire mode_clock_output_pin = (mode_r == MODE_EXT_CLOCK_OUTPUT_PIN) || (mode_r == MODE_INT_CLOCK_OUTPUT_PIN);
    // Sampled edge: an outside clock above half of aclk aliases
    wire ext_tick = cin_r && !cin_d_r;

    // ********************************************************
    // Register state
    // ********************************************************
    logic [1:0] fsel_r;
    logic [1:0] fsel_act_r;
    logic signed [TRIM_W-1:0] trim_r;
    logic signed [TRIM_W-1:0] trim_eff_r;
    logic [1:0] irq_stat_r, irq_en_r;
    logic [3:0] pin_ctrl_r;
    logic lock_r, stable_r;

    // ********************************************************
    // Internal oscillator model
    // ********************************************************
    logic [ACC_W-1:0] acc_r;
    logic [2:0] div_cnt_r;
    wire [ACC_W-1:0] inc_base = range_r ? INC_HF : INC_MF;
    wire signed [31:0] inc_step = 32'(signed'({1'b0, inc_base[ACC_W-1:7]}));
    wire signed [31:0] trim_wide = 32'(trim_eff_r);
    // Signed trim scales the rate linearly, so codes stay monotonic
    wire [31:0] inc_full = 32'(inc_base) + 32'(inc_step * trim_wide);
    wire [ACC_W:0] acc_sum = {1'b0, acc_r} + {1'b0, inc_full[ACC_W-1:0]};
    wire src_tick = acc_sum[ACC_W];
    wire [2:0] div_mask = 3'((4'h8 >> fsel_act_r) - 4'h1);
    // All postscaler outputs fire together here, so switching cannot glitch
    wire div_wrap = src_tick && (div_cnt_r == 3'h7);
    wire int_tick = src_tick && ((div_cnt_r & div_mask) == div_mask);
    wire sys_tick_nxt = mode_ext ? ext_tick : int_tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= '0;
            div_cnt_r <= 3'h0;
            fsel_act_r <= FSEL_RESET;
        end else begin
            acc_r <= acc_sum[ACC_W-1:0];
            if (src_tick) begin
                div_cnt_r <= div_cnt_r + 3'h1;
            end
            if (div_wrap) begin
                fsel_act_r <= fsel_r;
            end
        end
    end

    // ********************************************************
    // Lock, stability and gradual trim
    // ********************************************************
    logic [$clog2(STABLE_CNT+1)-1:0] stab_cnt_r;
    logic [$clog2(LOCK_CNT+1)-1:0] lock_cnt_r;
    logic [$clog2(TRIM_STEP_CNT+1)-1:0] step_cnt_r;
    wire trim_settled = (trim_eff_r == trim_r);
    wire lock_nxt = (32'(lock_cnt_r) >= LOCK_CNT);
    wire stable_nxt = lock_nxt && (32'(stab_cnt_r) >= STABLE_CNT) && trim_settled;
    wire step_due = (32'(step_cnt_r) >= TRIM_STEP_CNT) && !trim_settled;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_r <= '0;
            stab_cnt_r <= '0;
            step_cnt_r <= '0;
            trim_eff_r <= TRIM_RESET;
            lock_r <= 1'b0;
            stable_r <= 1'b0;
        end else begin
            if (!lock_nxt) begin
                lock_cnt_r <= lock_cnt_r + 1'b1;
            end
            if (32'(stab_cnt_r) < STABLE_CNT) begin
                stab_cnt_r <= stab_cnt_r + 1'b1;
            end
            step_cnt_r <= (step_due || trim_settled) ? '0 : step_cnt_r + 1'b1;
            if (step_due) begin
                trim_eff_r <= (trim_eff_r < trim_r) ? trim_eff_r + 6'sh01
                                                    : trim_eff_r - 6'sh01;
            end
            lock_r <= lock_nxt;
            stable_r <= stable_nxt;
        end
    end

    // ********************************************************
    // AXI4-Lite slave
    // ********************************************************
    logic aw_hold_r, w_hold_r;
    logic [7:0] awaddr_q_r;
    logic [31:0] wdata_q_r;
    logic wstrb_q_r;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire b_hs = s_axi_bvalid && s_axi_bready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire r_hs = s_axi_rvalid && s_axi_rready;
    wire do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
    wire wr_en = do_wr && wstrb_q_r;
    wire wr_fsel = wr_en && (awaddr_q_r == OFS_FREQ_CTRL);
    wire wr_trim = wr_en && (awaddr_q_r == OFS_TRIM);
    wire wr_clr = wr_en && (awaddr_q_r == OFS_IRQ_CLEAR);
    wire wr_en_reg = wr_en && (awaddr_q_r == OFS_IRQ_ENABLE);
    wire wr_pin = wr_en && (awaddr_q_r == OFS_PIN_CTRL);
    wire wr_map = (awaddr_q_r == OFS_FREQ_CTRL) || (awaddr_q_r == OFS_TRIM)
               || (awaddr_q_r == OFS_IRQ_STATUS) || (awaddr_q_r == OFS_IRQ_CLEAR)
               || (awaddr_q_r == OFS_IRQ_ENABLE) || (awaddr_q_r == OFS_PIN_CTRL)
               || (awaddr_q_r == OFS_PIN_STATUS);

    wire [31:0] freq_word = 32'({fsel_r, lock_r, stable_r, 2'h0});
    wire [31:0] trim_word = 32'(unsigned'(trim_r));
    wire [31:0] pin_status_word = 32'({range_r, mode_r, cout_r, cin_r});
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            OFS_FREQ_CTRL: rd_word = freq_word;
            OFS_TRIM: rd_word = trim_word;
            OFS_IRQ_STATUS: rd_word = 32'(irq_stat_r);
            OFS_IRQ_CLEAR: rd_word = 32'h0000_0000;
            OFS_IRQ_ENABLE: rd_word = 32'(irq_en_r);
            OFS_PIN_CTRL: rd_word = 32'(pin_ctrl_r);
            OFS_PIN_STATUS: rd_word = pin_status_word;
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_q_r <= 8'h00;
            wdata_q_r <= 32'h0000_0000;
            wstrb_q_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_hold_r <= 1'b1;
                awaddr_q_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_hold_r <= 1'b1;
                wdata_q_r <= s_axi_wdata;
                wstrb_q_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_hs) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (r_hs) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ********************************************************
    // Software registers and interrupts
    // ********************************************************
    wire [1:0] irq_evt = {stable_nxt && !stable_r, lock_nxt && !lock_r};
    wire [1:0] clr_bits = wr_clr ? wdata_q_r[1:0] : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fsel_r <= FSEL_RESET;
            trim_r <= TRIM_RESET;
            irq_stat_r <= 2'h0;
            irq_en_r <= 2'h0;
            pin_ctrl_r <= 4'h0;
        end else begin
            if (wr_fsel) begin
                fsel_r <= wdata_q_r[FSEL_LSB+1:FSEL_LSB];
            end
            if (wr_trim) begin
                trim_r <= signed'(wdata_q_r[TRIM_W-1:0]);
            end
            if (wr_en_reg) begin
                irq_en_r <= wdata_q_r[1:0];
            end
            if (wr_pin) begin
                pin_ctrl_r <= wdata_q_r[3:0];
            end
            // New events win over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~clr_bits) | irq_evt;
        end
    end

    // ********************************************************
    // Pin drivers and clock outputs
    // ********************************************************
    logic [1:0] quarter_r;
    wire [1:0] quarter_nxt = sys_tick_nxt ? quarter_r + 2'h1 : quarter_r;
    wire cout_out_nxt = mode_clock_output_pin ? quarter_nxt[1] : pin_ctrl_r[PIN_OUT_OUT_BIT];
    wire cout_oe_nxt = mode_clock_output_pin || pin_ctrl_r[PIN_OUT_OE_BIT];
    wire cin_oe_nxt = !mode_ext && pin_ctrl_r[PIN_IN_OE_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quarter_r <= 2'h0;
            sys_clk_tick <= 1'b0;
            clock_output_pin_out <= 1'b0;
            clock_output_pin_oe <= 1'b0;
            clock_input_pin_out <= 1'b0;
            clock_input_pin_oe <= 1'b0;
            irq <= 1'b0;
        end else begin
            quarter_r <= quarter_nxt;
            sys_clk_tick <= sys_tick_nxt;
            clock_output_pin_out <= cout_out_nxt;
            clock_output_pin_oe <= cout_oe_nxt;
            clock_input_pin_out <= pin_ctrl_r[PIN_IN_OUT_BIT];
            clock_input_pin_oe <= cin_oe_nxt;
            irq <= |(irq_stat_r & irq_en_r);
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fsel_reset_value: assert property ($rose(aresetn) |-> fsel_r == 2'h2)
        else $error("frequency select not 10 after reset");
    a_clock_output_pin_drive: assert property (mode_clock_output_pin |=> clock_output_pin_oe)
        else $error("clock output pin not driven in clock_output_pin mode");
    a_pins_free_io: assert property ((mode_r == MODE_INT_IO) && pin_ctrl_r == 4'h0
        |=> !clock_output_pin_oe && !clock_input_pin_oe)
        else $error("pin driven while released for I/O");
    a_ext_input_free: assert property (mode_ext |=> !clock_input_pin_oe)
        else $error("input clock pin driven in external mode");
    a_sel_switch_safe: assert property ($changed(fsel_act_r) |-> $past(div_wrap))
        else $error("postscaler switched off the wrap point");
    a_sel_follow_write: assert property (wr_fsel |-> ##[1:400] fsel_act_r == fsel_r)
        else $error("frequency selection not applied");
    a_lock_time: assert property ($rose(lock_r) |-> 32'(lock_cnt_r) == LOCK_CNT)
        else $error("lock flag at wrong time");
    a_stable_needs_lock: assert property (stable_r |-> lock_r && $past(trim_settled))
        else $error("stable flag without lock");
    a_trim_one_step: assert property ($changed(trim_eff_r) |->
        (6'(trim_eff_r - $past(trim_eff_r)) inside {6'h01, 6'h3F}))
        else $error("trim moved by more than one step");
    a_tick_from_source: assert property (!mode_ext && sys_tick_nxt |-> src_tick)
        else $error("internal tick without source tick");

    c_ext_tick: cover property (mode_ext ##1 sys_clk_tick);
    c_sel_switch: cover property (wr_fsel ##[1:400] $changed(fsel_act_r));
    c_trim_settle: cover property (wr_trim ##[1:1000] trim_settled);
    c_irq_raise: cover property ($rose(irq));

endmodule : scss_top

/* test_system_clock_source_select.sv */
`timescale 1ns/1ps
module test_system_clock_source_select
    import scss_pkg::*;
;
    localparam int TMO = 60000;
    localparam int WIN = 1600;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [1:0] source_mode_field = 2'h1;
    logic high_range_enable = 1'b1;
    logic clock_input_pin_in, clock_input_pin_out, clock_input_pin_oe;
    logic clock_output_pin_in, clock_output_pin_out, clock_output_pin_oe;
    logic sys_clk_tick, irq;
    logic run = 1'b0, gpio_lvl = 1'b0, co_prev = 1'b0;
    int err_total = 0, checks = 0, cyc = 0, tick_cnt = 0, co_cnt = 0;
    int t, c;

    // Short counts keep lock and trim scenarios brief
    scss_top #(.LOCK_CNT(8), .STABLE_CNT(16), .TRIM_STEP_CNT(2)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .source_mode_field, .high_range_enable,
        .clock_input_pin_in, .clock_input_pin_out, .clock_input_pin_oe,
        .clock_output_pin_in, .clock_output_pin_out, .clock_output_pin_oe,
        .sys_clk_tick, .irq);

    scss_ext_party partner (.aclk, .run, .gpio_lvl,
        .in_oe(clock_input_pin_oe), .in_out(clock_input_pin_out),
        .out_oe(clock_output_pin_oe), .out_out(clock_output_pin_out),
        .in_pin(clock_input_pin_in), .out_pin(clock_output_pin_in));

    initial begin
        forever #25 aclk = ~aclk;
    end

    // ****************************************
    // Free-running counters and hang guard
    // ****************************************
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        co_prev <= clock_output_pin_out;
        if (sys_clk_tick === 1'b1) tick_cnt <= tick_cnt + 1;
        if (clock_output_pin_out === 1'b1 && co_prev === 1'b0) co_cnt <= co_cnt + 1;
        if (cyc == TMO) begin
            err_total = err_total + 1;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic fail(input string m);
        err_total = err_total + 1;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks = checks + 1;
        if (got !== exp) fail($sformatf("%s got %h want %h", m, got, exp));
    endtask : check_val

    task automatic check_cnt(input int got, input int lo, input int hi, input string m);
        checks = checks + 1;
        if (got < lo || got > hi) fail($sformatf("%s count %0d out of %0d..%0d", m, got, lo, hi));
    endtask : check_cnt

    // ****************************************
    // Register bus master
    // ****************************************
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(s_axi_bvalid === 1'b1 && aw_ok && w_ok));
        s_axi_bready <= 1'b0;
        check_val(s_axi_bresp, er, "bresp");
    endtask : wr_chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check_val(s_axi_rdata, ed, "rdata");
        check_val(s_axi_rresp, er, "rresp");
    endtask : rd_chk

    task automatic do_reset(input logic [1:0] m, input logic hr);
        @(posedge aclk);
        aresetn <= 1'b0;
        source_mode_field <= m;
        high_range_enable <= hr;
        run <= m[1];
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (40) @(posedge aclk);
    endtask : do_reset

    task automatic measure(input int n, output int tn, output int cn);
        int t0, c0;
        t0 = tick_cnt;
        c0 = co_cnt;
        repeat (n) @(posedge aclk);
        tn = tick_cnt - t0;
        cn = co_cnt - c0;
    endtask : measure

    // Waits past the slowest postscaler wrap before counting
    task automatic sweep(input logic hr);
        int src, e, tn, cn;
        src = hr ? HF_FREQ_KHZ : REF_FREQ_KHZ;
        for (int k = 3; k >= 0; k--) begin
            wr_chk(OFS_FREQ_CTRL, 32'(k) << FSEL_LSB, RESP_OKAY);
            repeat (400) @(posedge aclk);
            measure(WIN, tn, cn);
            e = (src * WIN / CLK_FREQ_KHZ) >> (3 - k);
            check_cnt(tn, e - 2, e + 2, "tick");
            check_cnt(cn, e / 4 - 2, e / 4 + 2, "clock_output_pin");
            rd_chk(OFS_FREQ_CTRL, (32'(k) << FSEL_LSB) | 32'hC, RESP_OKAY);
        end
    endtask : sweep

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFS_FREQ_CTRL, 32'h20, RESP_OKAY);
        rd_chk(OFS_TRIM, 32'h0, RESP_OKAY);
        rd_chk(8'h40, 32'h0, RESP_SLVERR);
        wr_chk(8'h40, 32'hFF, RESP_SLVERR);
        repeat (40) @(posedge aclk);
        rd_chk(OFS_FREQ_CTRL, 32'h2C, RESP_OKAY);
        rd_chk(OFS_IRQ_STATUS, 32'h3, RESP_OKAY);
        check_val(irq, 32'h0, "irq masked");
        for (int b = 0; b < 2; b++) begin
            wr_chk(OFS_IRQ_ENABLE, 32'h1 << b, RESP_OKAY);
            repeat (2) @(posedge aclk);
            check_val(irq, 32'h1, "irq set");
            wr_chk(OFS_IRQ_CLEAR, 32'h1 << b, RESP_OKAY);
            repeat (2) @(posedge aclk);
            check_val(irq, 32'h0, "irq clear");
            rd_chk(OFS_IRQ_STATUS, 32'h2 >> b >> b, RESP_OKAY);
        end
        $display("test registers done");
        sweep(1'b1);
        wr_chk(OFS_PIN_CTRL, 32'h3, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check_val({clock_input_pin_oe, clock_input_pin_out, clock_output_pin_oe}, 32'h7,
            "int clock_output_pin pins");
        wr_chk(OFS_TRIM, 32'h1F, RESP_OKAY);
        rd_chk(OFS_TRIM, 32'h1F, RESP_OKAY);
        repeat (300) @(posedge aclk);
        measure(WIN, t, c);
        check_cnt(t, 180, 215, "trim max");
        wr_chk(OFS_TRIM, 32'hE0, RESP_OKAY);
        rd_chk(OFS_TRIM, 32'h20, RESP_OKAY);
        repeat (300) @(posedge aclk);
        measure(WIN, t, c);
        check_cnt(t, 105, 135, "trim min");
        $display("test high range done");
        do_reset(MODE_INT_CLOCK_OUTPUT_PIN, 1'b0);
        sweep(1'b0);
        $display("test low range done");
        do_reset(MODE_INT_IO, 1'b1);
        wr_chk(OFS_PIN_CTRL, 32'hF, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check_val({clock_input_pin_oe, clock_input_pin_out, clock_output_pin_oe,
            clock_output_pin_out}, 32'hF, "io pins");
        wr_chk(OFS_PIN_CTRL, 32'h0, RESP_OKAY);
        gpio_lvl <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(OFS_PIN_STATUS, 32'h13, RESP_OKAY);
        $display("test io mode done");
        do_reset(MODE_EXT_IO, 1'b1);
        wr_chk(OFS_PIN_CTRL, 32'hF, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check_val({clock_input_pin_oe, clock_output_pin_oe}, 32'h1, "ext io pins");
        measure(800, t, c);
        check_cnt(t, 97, 103, "ext tick");
        rd_chk(OFS_PIN_STATUS, {27'h0, 5'h1A} | 32'(clock_input_pin_in), RESP_OKAY);
        $display("test ext io done");
        do_reset(MODE_EXT_CLOCK_OUTPUT_PIN, 1'b1);
        measure(800, t, c);
        check_cnt(t, 97, 103, "ext tick");
        check_cnt(c, 23, 27, "ext clock_output_pin");
        check_val(clock_output_pin_oe, 32'h1, "ext clock_output_pin oe");
        $display("test ext clock_output_pin done");
        give_verdict();
    end
endmodule : test_system_clock_source_select
